// *** logic/ssrc_map.svh ***
// Purpose: constants of the sensor request framer and command crc check
// Assumes: included by the package and by the top file, guarded against repeats
// Notes:   offsets are bit positions inside the 32-bit frame
`ifndef SSRC_MAP_SVH
`define SSRC_MAP_SVH

// frame length and field positions
`define SSRC_FRAME_BITS   6'd32
`define SSRC_BODY_BITS    24
`define SSRC_CMD_HI       31
`define SSRC_CMD_LO       28
`define SSRC_ST_HI        27
`define SSRC_ST_LO        26
`define SSRC_SD_HI        25
`define SSRC_SD_LO        14
`define SSRC_EXT_HI       13
`define SSRC_EXT_LO       10
`define SSRC_SF_HI        9
`define SSRC_SF_LO        8

// crc generator x^8+x^5+x^3+x^2+x+1 and seeds
`define SSRC_CRC_POLY     8'h2F
`define SSRC_SEED_FULL    8'hFF
`define SSRC_SEED_HI      4'hF

// command nibbles of the register commands
`define SSRC_CMD_WRITE    4'h8
`define SSRC_CMD_READ     4'hC

// basic status codes and the spi error code of the detailed status field
`define SSRC_ST_INIT      2'h0
`define SSRC_ST_NORMAL    2'h1
`define SSRC_ST_SELFTEST  2'h2
`define SSRC_ST_ERROR     2'h3
`define SSRC_SF_SPI_ERR   2'h3

`endif

// *** logic/ssrc_pkg.sv ***
// Purpose: types and crc helpers shared by the framer files
// Assumes: constants come from ssrc_map.svh
// Notes:   crc helpers are combinational, msb first
`include "ssrc_map.svh"
`default_nettype none

package ssrc_pkg;

	// kind of answer prepared for the next transfer
	typedef enum logic [1:0] {RSP_ERROR, RSP_SENSOR, RSP_RESERVED, RSP_REGISTER} ssrc_rsp_t;

	// seed from the configured nibble, zero means all ones
	function automatic logic [7:0] ssrc_seed(input logic [3:0] nib);
		ssrc_seed = (nib == 4'h0) ? `SSRC_SEED_FULL : {`SSRC_SEED_HI, nib};
	endfunction

	// one serial step: bit enters at the low end
	function automatic logic [7:0] ssrc_step(input logic [7:0] r, input logic b);
		ssrc_step = {r[6:0], b} ^ (r[7] ? `SSRC_CRC_POLY : 8'h00);
	endfunction

	// transmit crc: 24 message bits then 8 zero flush bits
	function automatic logic [7:0] ssrc_crc_word(input logic [7:0] seed, input logic [23:0] body);
		logic [7:0] r;
		r = seed;
		for (int i = `SSRC_BODY_BITS - 1; i >= 0; i--)
		begin
			r = ssrc_step(r, body[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			r = ssrc_step(r, 1'b0);
		end
		ssrc_crc_word = r;
	endfunction

endpackage : ssrc_pkg

`default_nettype wire

// *** logic/ssrc_crc8.sv ***
// Purpose: serial crc checker for received command bits
// Assumes: shift pulses come in arrival order, msb first
// Notes:   a zero remainder after the last crc bit means pass
`default_nettype none

module ssrc_crc8
	import ssrc_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic       load_i,
	input  wire logic [7:0] seed_i,
	input  wire logic       shift_i,
	input  wire logic       bit_i,
	output logic            zero_o
);

	logic [7:0] crc_reg;
	logic [7:0] crc_next;

	////////////////////////////////////////////////////////////////////////
	// seed load wins over a shift in the same cycle
	assign crc_next = load_i ? seed_i : (shift_i ? ssrc_step(crc_reg, bit_i) : crc_reg);
	assign zero_o   = (crc_reg == 8'h00);

	// register, frozen while clock enable is low
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			crc_reg <= 8'hFF;
		else if (ce_i)
			crc_reg <= crc_next;
	end

endmodule // ssrc_crc8

`default_nettype wire

// *** logic/ssrc_top.sv ***
// Purpose: 32-bit spi target framing, command decode and command crc check
// Assumes: spi mode 0, pins sampled by core_clk_i at 40 MHz
// Notes:   response to a frame is sent during the following frame
`include "ssrc_map.svh"
`default_nettype none

module ssrc_top
	import ssrc_pkg::*;
#(
	parameter int SENS_W = 16
)
(
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	input  wire logic              ce_i,
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic              mosi_i,
	input  wire logic [3:0]        crc_seed_nibble_i,
	input  wire logic              wide_data_i,
	input  wire logic [SENS_W-1:0] sensor_value_i,
	input  wire logic              init_done_lock_i,
	input  wire logic              self_test_i,
	input  wire logic              int_error_i,
	input  wire logic [1:0]        detailed_status_i,
	input  wire logic              err_req_i,
	input  wire logic [23:0]       reg_resp_i,
	output logic                   miso_o,
	output logic                   miso_oe_o,
	output logic [2:0]             source_selector_o,
	output logic                   sensor_req_o,
	output logic                   reg_cmd_o,
	output logic [31:0]            cmd_word_o,
	output logic                   crc_ok_o,
	output logic                   frame_err_o
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: bit 0 sclk, bit 1 select, bit 2 mosi
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       sclk_prev_reg;
	logic       cs_prev_reg;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sync1_reg     <= 3'h2;
			sync2_reg     <= 3'h2;
			sclk_prev_reg <= 1'b0;
			cs_prev_reg   <= 1'b1;
		end
		else if (ce_i)
		begin
			sync1_reg     <= {mosi_i, cs_n_i, sclk_i};
			sync2_reg     <= sync1_reg;
			sclk_prev_reg <= sync2_reg[0];
			cs_prev_reg   <= sync2_reg[1];
		end
	end

	// edge detection on the synchronised copies only
	wire logic sclk_s    = sync2_reg[0];
	wire logic cs_n_s    = sync2_reg[1];
	wire logic mosi_s    = sync2_reg[2];
	wire logic cs_fall   = cs_prev_reg & ~cs_n_s;
	wire logic cs_rise   = ~cs_prev_reg & cs_n_s;
	wire logic sclk_rise = ~sclk_prev_reg & sclk_s & ~cs_n_s;
	wire logic sclk_fall = sclk_prev_reg & ~sclk_s & ~cs_n_s;

	////////////////////////////////////////////////////////////////////////
	// frame state
	logic [5:0]  count_reg;
	logic [31:0] rx_reg;
	logic [31:0] tx_reg;
	logic        bad_edge_reg;
	logic        check_reg;
	ssrc_rsp_t   pend_reg;
	ssrc_rsp_t   pend_next;
	logic [1:0]  st_reg;
	logic [1:0]  sf_reg;
	logic [3:0]  echo_reg;
	logic        crc_zero;

	wire logic [7:0] seed = ssrc_seed(crc_seed_nibble_i);

	// bits shift in as they arrive
	ssrc_crc8 u_crc
	(
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ce_i       (ce_i),
		.load_i     (cs_fall),
		.seed_i     (seed),
		.shift_i    (sclk_rise),
		.bit_i      (mosi_s),
		.zero_o     (crc_zero)
	);

	// msb first into the receive register
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_reg    <= 32'h0000_0000;
			count_reg <= 6'h00;
			check_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			check_reg <= sclk_rise && (count_reg == `SSRC_FRAME_BITS - 6'd1);
			if (cs_fall)
				count_reg <= 6'h00;
			else if (sclk_rise && count_reg != 6'h3F)
				count_reg <= count_reg + 6'd1;
			if (sclk_rise)
				rx_reg <= {rx_reg[30:0], mosi_s};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result taken after the 32nd bit
	// held until the next select fall
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			crc_ok_o <= 1'b0;
		else if (ce_i)
		begin
			if (cs_fall)
				crc_ok_o <= 1'b0;
			else if (check_reg)
				crc_ok_o <= crc_zero;
		end
	end

	// sclk must idle low at both select edges
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			bad_edge_reg <= 1'b0;
		else if (ce_i && cs_fall)
			bad_edge_reg <= sclk_s;
	end

	////////////////////////////////////////////////////////////////////////
	// execution needs a pass and exactly 32 clean bits
	wire logic [3:0] cmd_nib   = rx_reg[`SSRC_CMD_HI:`SSRC_CMD_LO];
	wire logic       frame_ok  = ~bad_edge_reg & ~sclk_s & (count_reg == `SSRC_FRAME_BITS) & crc_ok_o;
	wire logic       is_sensor = cmd_nib[0];
	wire logic       is_reg    = (cmd_nib == `SSRC_CMD_WRITE) | (cmd_nib == `SSRC_CMD_READ);

	// any failure turns the next answer into the error answer
	// leftover nibbles are reserved and execute nothing
	always_comb
	begin
		if (!frame_ok || err_req_i)
			pend_next = RSP_ERROR;
		else if (is_sensor)
			pend_next = RSP_SENSOR;
		else if (is_reg)
			pend_next = RSP_REGISTER;
		else
			pend_next = RSP_RESERVED;
	end

	// basic status encoding, error has top priority
	wire logic [1:0] st_now = int_error_i      ? `SSRC_ST_ERROR :
	                          self_test_i      ? `SSRC_ST_SELFTEST :
	                          !init_done_lock_i ? `SSRC_ST_INIT : `SSRC_ST_NORMAL;

	// decode and status capture at select release
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pend_reg          <= RSP_RESERVED;
			st_reg            <= `SSRC_ST_INIT;
			sf_reg            <= 2'h0;
			echo_reg          <= 4'h0;
			source_selector_o <= 3'h0;
			sensor_req_o      <= 1'b0;
			reg_cmd_o         <= 1'b0;
			cmd_word_o        <= 32'h0000_0000;
			frame_err_o       <= 1'b0;
		end
		else if (ce_i)
		begin
			sensor_req_o <= cs_rise && pend_next == RSP_SENSOR;
			reg_cmd_o    <= cs_rise && pend_next == RSP_REGISTER;
			frame_err_o  <= cs_rise && pend_next == RSP_ERROR;
			if (cs_rise)
			begin
				pend_reg   <= pend_next;
				st_reg     <= st_now;
				sf_reg     <= detailed_status_i;
				echo_reg   <= cmd_nib;
				cmd_word_o <= rx_reg;
				// selector taken from upper command bits
				if (pend_next == RSP_SENSOR)
					source_selector_o <= cmd_nib[3:1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answer assembly at select fall
	logic [SENS_W-1:0] val;
	logic [11:0]       sd_field;
	logic [3:0]        ext_field;
	logic [23:0]       body;

	// 16-bit mode moves the low nibble into the optional field
	assign val       = sensor_value_i;
	assign sd_field  = wide_data_i ? val[15:4] : val[11:0];
	assign ext_field = wide_data_i ? val[3:0] : 4'h0;

	// reserved answer echoes the nibble, data zero
	always_comb
	begin
		case (pend_reg)
			RSP_SENSOR:
				body = {source_selector_o, 1'b1, st_reg, sd_field, ext_field, sf_reg};
			RSP_RESERVED:
				body = {echo_reg, 20'h00000};
			RSP_REGISTER:
				body = reg_resp_i;
			RSP_ERROR:
				body = {4'h0, `SSRC_ST_ERROR, 16'h0000, `SSRC_SF_SPI_ERR};
			default:
				body = {4'h0, `SSRC_ST_ERROR, 16'h0000, `SSRC_SF_SPI_ERR};
		endcase
	end

	wire logic [31:0] resp_word = {body, ssrc_crc_word(seed, body)};

	////////////////////////////////////////////////////////////////////////
	// sensor value frozen into the shifter at select fall
	// previous frame's answer goes out now
	// reserved answer also follows the next select fall
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_reg    <= 32'h0000_0000;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cs_fall)
			begin
				tx_reg    <= resp_word;
				miso_o    <= resp_word[31];
				miso_oe_o <= 1'b1;
			end
			else if (cs_rise)
				miso_oe_o <= 1'b0;
			else if (sclk_fall)
			begin
				// next bit on falling edge, host samples on rising
				tx_reg <= {tx_reg[30:0], 1'b0};
				miso_o <= tx_reg[30];
			end
		end
	end

endmodule // ssrc_top

`default_nettype wire

// *** test/ssrc_top_sva.sv ***
// Purpose: port checks of the framer
// Assumes: ce_i held high
// Notes:   windows allow for the pin synchronisers
`default_nettype none

module ssrc_top_chk (
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	input wire logic        cs_n_i,
	input wire logic        miso_oe_o,
	input wire logic [2:0]  source_selector_o,
	input wire logic        sensor_req_o,
	input wire logic        reg_cmd_o,
	input wire logic [31:0] cmd_word_o,
	input wire logic        crc_ok_o,
	input wire logic        frame_err_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	////////////////////////////////
	// select fall and eight-cycle low run as the core clock sees them
	sequence s_fall;
		$fell(cs_n_i);
	endsequence
	sequence s_low8;
		(!cs_n_i) [*8];
	endsequence

	property p_oe_on;
		s_fall |-> ##[2:6] miso_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("miso not enabled");
	property p_oe_off;
		cs_n_i [*6] |-> !miso_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso enabled while idle");
	property p_ok_clr;
		s_fall |-> ##[2:6] !crc_ok_o;
	endproperty
	a_ok_clr: assert property (p_ok_clr) else $error("crc result not cleared");
	// result must not drop mid frame
	property p_ok_hold;
		s_low8 ##0 crc_ok_o |=> crc_ok_o;
	endproperty
	a_ok_hold: assert property (p_ok_hold) else $error("crc result lost");
	property p_sens;
		sensor_req_o |-> crc_ok_o && cmd_word_o[28] && source_selector_o == cmd_word_o[31:29];
	endproperty
	a_sens: assert property (p_sens) else $error("bad sensor request");
	property p_reg;
		reg_cmd_o |-> crc_ok_o && cmd_word_o[31:28] inside {4'h8, 4'hC};
	endproperty
	a_reg: assert property (p_reg) else $error("bad register command");
	property p_err;
		frame_err_o |-> !sensor_req_o && !reg_cmd_o && $past(cs_n_i, 2);
	endproperty
	a_err: assert property (p_err) else $error("rejected frame executed");
	property p_pulse;
		sensor_req_o |-> $past(cs_n_i, 2) ##1 (!sensor_req_o) [*4];
	endproperty
	a_pulse: assert property (p_pulse) else $error("request pulse misplaced");
endmodule // ssrc_top_chk

bind ssrc_top ssrc_top_chk chk_u (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .miso_oe_o(miso_oe_o),
	.source_selector_o(source_selector_o), .sensor_req_o(sensor_req_o), .reg_cmd_o(reg_cmd_o),
	.cmd_word_o(cmd_word_o), .crc_ok_o(crc_ok_o), .frame_err_o(frame_err_o)
);

`default_nettype wire

// *** test/ssrc_host.sv ***
// Purpose: spi initiator model
// Assumes: mode 0, 200 ns sclk period, msb first
// Notes:   released mosi shows the inverted last bit
`default_nettype none

module ssrc_host (
	input  wire logic [3:0] seed_nib_i,
	input  wire logic       miso_i,
	output logic            sclk_o,
	output logic            cs_n_o,
	output logic            mosi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// crc: seed, 24 bits, 8 zeros
	function automatic logic [7:0] crc(input logic [23:0] b);
		logic [7:0] r;
		r = (seed_nib_i == 4'h0) ? 8'hFF : {4'hF, seed_nib_i};
		for (int i = 31; i >= 0; i--)
			r = {r[6:0], (i > 7) ? b[i-8] : 1'b0} ^ (r[7] ? 8'h2F : 8'h00);
		crc = r;
	endfunction

	// frame: sclk idles low, miso read late in high phase
	// hot holds sclk high across the select fall, a framing fault
	task automatic xfer(input logic [31:0] tx, input int n, input logic hot, output logic [31:0] rx);
		sclk_o = hot;
		#100 cs_n_o = 1'b0;
		#100 sclk_o = 1'b0;
		#50;
		for (int i = 31; i > 31 - n; i--)
		begin
			mosi_o = tx[i];
			#50 sclk_o = 1'b1;
			#100 rx[i] = miso_i;
			sclk_o = 1'b0;
			#50;
		end
		mosi_o = ~mosi_o;
		#100 cs_n_o = 1'b1;
		#400;
	endtask
endmodule // ssrc_host

`default_nettype wire

// *** test/ssrc_top_tb.sv ***
// Purpose: self-checking bench of the framer
// Assumes: answer to a frame comes in the next frame
// Notes:   reserved answers are judged on their crc only
`default_nettype none

module ssrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        sclk, cs_n, mosi, miso, miso_oe, sreq, rcmd, crc_ok, ferr;
	logic [3:0]  seed = 4'h0;
	logic        wide = 1'b0;
	logic [15:0] sval = 16'h0;
	logic        init_ok = 1'b1, stest = 1'b0, ierr = 1'b0, ereq = 1'b0;
	logic [1:0]  dstat = 2'h2;
	logic [23:0] rresp = 24'h5A0F3C;
	logic [23:0] r;
	logic [3:0]  p = 4'h0;
	logic        hot = 1'b0;
	int          n_sreq = 0, n_rcmd = 0, n_ferr = 0, e_sreq = 0;
	logic [2:0]  src;
	logic [31:0] cword, rx, tx, errw;
	int          mismatches = 0, total_checks = 0;
	logic [23:0] rows [14] = '{24'h10ABCD, 24'h050123, 24'h3A8001, 24'h2F7FFF, 24'h531234,
		24'h400FFF, 24'h7E8000, 24'h630001, 24'h914321, 24'hA2FFFF, 24'hB60F0F,
		24'hE9F0F0, 24'hD10246, 24'hF4ACE1};

	initial
		forever #12.5 core_clk_i = ~core_clk_i;

	ssrc_top dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .sclk_i(sclk),
		.cs_n_i(cs_n), .mosi_i(mosi), .crc_seed_nibble_i(seed), .wide_data_i(wide),
		.sensor_value_i(sval), .init_done_lock_i(init_ok), .self_test_i(stest),
		.int_error_i(ierr), .detailed_status_i(dstat), .err_req_i(ereq), .reg_resp_i(rresp),
		.miso_o(miso), .miso_oe_o(miso_oe), .source_selector_o(src), .sensor_req_o(sreq),
		.reg_cmd_o(rcmd), .cmd_word_o(cword), .crc_ok_o(crc_ok), .frame_err_o(ferr));
	ssrc_host host_u (.seed_nib_i(seed), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

	// pulse counters on the falling edge, where the registered pulses are settled
	always @(negedge core_clk_i)
	begin
		n_sreq <= n_sreq + int'(sreq);
		n_rcmd <= n_rcmd + int'(rcmd);
		n_ferr <= n_ferr + int'(ferr);
	end

	////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// sensor answer with current value, mode and seed
	function automatic logic [31:0] sens(input logic [3:0] nib, input logic [1:0] st);
		logic [23:0] b;
		b = {nib[3:1], 1'b1, st, wide ? sval : {sval[11:0], 4'h0}, dstat};
		sens = {b, host_u.crc(b)};
	endfunction

	// fl corrupts the crc byte on purpose
	task automatic frame(input logic [23:0] b, input int n, input logic [7:0] fl);
		@(negedge core_clk_i);
		tx = {b, host_u.crc(b) ^ fl};
		host_u.xfer(tx, n, hot, rx);
	endtask

	// one command under sclk fault and status s, then its answer
	task automatic pair(input logic [23:0] b, input int n, input logic [7:0] fl,
		input logic [4:0] s, input logic [31:0] e);
		@(negedge core_clk_i);
		{hot, init_ok, stest, ierr, ereq} = s;
		frame(b, n, fl);
		chk("crc ok", 32'(crc_ok), 32'(fl == 8'h00 && n == 32));
		@(negedge core_clk_i);
		{hot, init_ok, stest, ierr, ereq} = 5'h08;
		frame(24'h0, 32, 8'h00);
		chk("answer", rx, e);
	endtask

	////////////////////////////////
	// hang guard well beyond the run length
	initial
	begin
		#1000000;
		mismatches++;
		final_report();
	end

	initial
	begin
		repeat (3) @(negedge core_clk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		for (int i = 0; i < 15; i++)
		begin
			r = rows[i % 14];
			@(negedge core_clk_i);
			seed = r[19:16];
			wide = i[0];
			sval = r[15:0];
			frame({r[23:20], 20'h0}, 32, 8'h00);
			if (p[0])
				chk("sensor", rx, sens(p, 2'h1));
			else
				chk("reserved", 32'(rx[7:0]), 32'(host_u.crc(rx[31:8])));
			chk("word", cword, tx);
			chk("crc ok", 32'(crc_ok), 32'h1);
			if (r[20])
			begin
				e_sreq++;
				chk("selector", 32'(src), 32'(r[23:21]));
			end
			chk("sensor pulses", n_sreq, e_sreq);
			p = r[23:20];
		end
		chk("other pulses", n_rcmd + n_ferr, 0);
		errw = {24'h0C0003, host_u.crc(24'h0C0003)};
		pair(24'h300000, 32, 8'h01, 5'h08, errw);
		pair(24'h300000, 31, 8'h00, 5'h08, errw);
		pair(24'h300000, 32, 8'h00, 5'h09, errw);
		pair(24'h300000, 32, 8'h00, 5'h18, errw);
		pair(24'h500000, 32, 8'h00, 5'h00, sens(4'h5, 2'h0));
		pair(24'h500000, 32, 8'h00, 5'h0C, sens(4'h5, 2'h2));
		pair(24'h500000, 32, 8'h00, 5'h0E, sens(4'h5, 2'h3));
		pair(24'h812345, 32, 8'h00, 5'h08, {rresp, host_u.crc(rresp)});
		pair(24'hC10000, 32, 8'h00, 5'h08, {rresp, host_u.crc(rresp)});
		chk("sensor pulses", n_sreq, e_sreq + 3);
		chk("register pulses", n_rcmd, 2);
		chk("error pulses", n_ferr, 4);
		// reset in mid run clears outputs
		@(negedge core_clk_i);
		nrst_i = 1'b0;
		@(negedge core_clk_i);
		chk("word", cword, 32'h0);
		chk("flags", 32'({src, sreq, rcmd, crc_ok, ferr, miso, miso_oe}), 32'h0);
		nrst_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		frame(24'h100000, 32, 8'h00);
		chk("pending", 32'(rx[7:0]), 32'(host_u.crc(rx[31:8])));
		final_report();
	end
endmodule // ssrc_top_tb

`default_nettype wire
